// *** dv/spvc_llc_model.sv ***
// Purpose: Link-layer controller as AHB-Lite master of the bank.
// Assumes: Single word transfers, one at a time.
// Notes: Released data is inverted so stale values never look valid.
`timescale 1ns/100ps
module spvc_llc_model (
	// Clock
	input wire logic         core_clk,
	// AHB-Lite master
	output logic             hsel,
	output logic [31:0]      haddr,
	output logic [1:0]       htrans,
	output logic             hwrite,
	output logic [2:0]       hsize,
	output logic [31:0]      hwdata,
	input wire logic         hready,
	input wire logic [31:0]  hrdata
);
	// Idle bus from time zero
	initial
	begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'hA5A5A5A5;
	end

	// One transfer; waits on hready, only the bench timeout ends a hang
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge core_clk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		hwdata <= ~hwdata;
		do @(posedge core_clk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= w ? d : ~hwdata;
		do @(posedge core_clk); while (hready !== 1'b1);
		q = hrdata;
	endtask
endmodule

// *** dv/spvc_top_properties.sv ***
// Purpose: Port assertions for the vendor control bank.
// Assumes: One AHB-Lite slave, so hready follows hreadyout.
// Notes: Request checks skip soft reset, which clears both pending requests anyway.
`timescale 1ns/100ps
`include "spvc_map.svh"
module spvc_top_properties #(
	parameter int PKT_BITS_W = 16
) (
	// Clock and reset
	input wire logic                  core_clk,
	input wire logic                  resetn,
	// Bus
	input wire logic                  hsel,
	input wire logic [31:0]           haddr,
	input wire logic [1:0]            htrans,
	input wire logic                  hwrite,
	input wire logic                  hready,
	input wire logic                  hreadyout,
	input wire logic [31:0]           hrdata,
	input wire logic                  hresp,
	// Requests
	input wire logic                  pkt_rx_done,
	input wire logic [PKT_BITS_W-1:0] pkt_rx_bits,
	input wire logic                  fair_req_set,
	input wire logic                  pri_req_set,
	input wire logic                  fair_req_pending,
	input wire logic                  pri_req_pending,
	// Self-ID and reset
	input wire logic [1:0]            self_id_speed_field,
	input wire logic [2:0]            peer_speed_code,
	input wire logic                  soft_reset_active
);
	logic rd_q;
	logic swr_q;
	logic take;

	// Taken read, and whether it hit the reset word
	assign take = hsel && hready && htrans[1] && !hwrite;
	always_ff @(posedge core_clk)
	begin
		rd_q  <= resetn && take;
		swr_q <= resetn && take && haddr[7:0] == `SPVC_ADDR_VRST;
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);

	no_wait_a: assert property (hreadyout && !hresp)
		else $error("wait state or error response");
	rdata_idle_a: assert property (!rd_q |-> hrdata == 32'h0)
		else $error("read data outside data phase");
	swr_reads_zero_a: assert property (swr_q |-> hrdata == 32'h0)
		else $error("soft reset bit read nonzero");
	peer_s400_a: assert property (peer_speed_code == `SPVC_PEER_S400)
		else $error("peer speed not S400");
	speed_legal_a: assert property (self_id_speed_field != 2'h3)
		else $error("illegal self-ID speed");
	speed_reset_a: assert property ($rose(resetn) |-> self_id_speed_field == 2'h2)
		else $error("speed not S400 after reset");
	// Long packets clear under either policy
	req_clear_a: assert property (pkt_rx_done && pkt_rx_bits > 8 && !fair_req_set
		&& !pri_req_set && !soft_reset_active |=> !fair_req_pending && !pri_req_pending)
		else $error("long packet left request pending");
	// An ack of exactly eight bits never clears
	ack_keep_a: assert property (pkt_rx_done && pkt_rx_bits == 8 && fair_req_pending
		&& !soft_reset_active |=> fair_req_pending)
		else $error("ack packet cleared request");
	swr_ends_a: assert property ($rose(soft_reset_active) |-> ##[4:8] !soft_reset_active)
		else $error("soft reset length wrong");
	swr_clears_a: assert property ($fell(soft_reset_active) |-> !fair_req_pending)
		else $error("soft reset kept request");

	cover property (pkt_rx_done && pkt_rx_bits == 8 && fair_req_pending);
	cover property ($rose(soft_reset_active));
	cover property (swr_q);
endmodule

// *** dv/test_serial_bus_phy_vendor_controls.sv ***
// Purpose: Self-checking bench of the vendor control bank.
// Assumes: Bus partner model drives every register access.
// Notes: Request policy is drawn at random from a fixed seed.
`timescale 1ns/100ps
`include "spvc_map.svh"
module test_serial_bus_phy_vendor_controls;
	logic core_clk = 1'b0;
	logic resetn, arb_accel_en, pkt_rx_done, fair_req_set, pri_req_set;
	logic [15:0] pkt_rx_bits;
	logic [2:0] power_class_straps;
	wire logic hsel, hwrite, hreadyout, hresp, fair_req_pending, pri_req_pending, soft_reset_active;
	wire logic [31:0] haddr, hwdata, hrdata;
	wire logic [1:0] htrans, self_id_speed_field;
	wire logic [2:0] hsize, peer_speed_code, self_id_power_field;
	wire spvc_pkg::spvc_pwr_kind_t power_class_kind;
	int fails = 0;
	int cmp_count = 0;
	integer seed = 32'h0781;
	logic [31:0] q;
	logic [2:0] s;
	logic pol, acc;
	int i, n, bits;

	spvc_top #(.PKT_BITS_W(16)) u_dut (.core_clk(core_clk), .resetn(resetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
		.arb_accel_en(arb_accel_en), .pkt_rx_done(pkt_rx_done), .pkt_rx_bits(pkt_rx_bits),
		.fair_req_set(fair_req_set), .pri_req_set(pri_req_set),
		.power_class_straps(power_class_straps), .fair_req_pending(fair_req_pending),
		.pri_req_pending(pri_req_pending), .self_id_speed_field(self_id_speed_field),
		.peer_speed_code(peer_speed_code), .self_id_power_field(self_id_power_field),
		.power_class_kind(power_class_kind), .soft_reset_active(soft_reset_active));
	spvc_llc_model u_llc (.core_clk(core_clk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata));

	// Clock, 8 ns period
	always #4 core_clk = ~core_clk;

	task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		cmp_count++;
		if (got !== exp)
		begin
			fails++;
			$display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask

	task chk_kind(input spvc_pkg::spvc_pwr_kind_t got, input spvc_pkg::spvc_pwr_kind_t exp);
		cmp_count++;
		if (got !== exp)
		begin
			fails++;
			$display("[FAIL] %0t power kind got %0d exp %0d", $time, got, exp);
		end
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] dummy;
		u_llc.xfer(1'b1, a, d, dummy);
	endtask

	task rd(input logic [7:0] a);
		u_llc.xfer(1'b0, a, 32'h0, q);
	endtask

	// Requests survive only what the policy spares
	function automatic logic clears(input logic p, input logic e, input int b);
		return (p && e) ? (b > 8) : (b != 8);
	endfunction

	function automatic spvc_pkg::spvc_pwr_kind_t exp_kind(input logic [2:0] c);
		if (c == 3'h0)
			return spvc_pkg::SPVC_PWR_NONE;
		if (c <= 3'h3)
			return spvc_pkg::SPVC_PWR_SELF_SRC;
		if (c == 3'h4)
			return spvc_pkg::SPVC_PWR_BUS_SRC;
		if (c == 3'h5)
			return spvc_pkg::SPVC_PWR_RESERVED;
		return spvc_pkg::SPVC_PWR_NEED_LINK;
	endfunction

	task complete_run;
		$display("Comparisons %0d, mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Hang guard, far beyond the few hundred cycles needed
	initial
	begin
		repeat (20000) @(posedge core_clk);
		fails++;
		complete_run;
	end

	// Main sequence
	initial
	begin
		resetn = 1'b0;
		arb_accel_en = 1'b0;
		pkt_rx_done = 1'b0;
		pkt_rx_bits = 16'h0;
		fair_req_set = 1'b0;
		pri_req_set = 1'b0;
		power_class_straps = 3'h6;
		repeat (8) @(posedge core_clk);
		resetn <= 1'b1;
		repeat (3) @(posedge core_clk);
		chk(self_id_power_field, 3'h6, "strap class");
		chk(peer_speed_code, 3'h2, "peer speed");
		chk(self_id_speed_field, 2'h2, "reset speed");
		wr(`SPVC_ADDR_PAGE, 32'hE0);
		rd(`SPVC_ADDR_VCTL);
		chk(q, 32'h02, "vendor reset value");
		rd(8'h44);
		chk(q, 32'h0, "unmapped read");
		$display("test reset done");
		// Every speed code; the illegal one keeps S400
		for (i = 0; i < 4; i++)
		begin
			wr(`SPVC_ADDR_VCTL, {24'h0, i[0], 5'h0, i[1:0]});
			rd(`SPVC_ADDR_VCTL);
			chk(q, {24'h0, i[0], 5'h0, (i == 3) ? 2'h2 : i[1:0]}, "speed field");
			chk(self_id_speed_field, (i == 3) ? 2'h2 : i[1:0], "self-ID speed");
		end
		$display("test speed done");
		// Random policy, acceleration and packet length
		for (i = 0; i < 30; i++)
		begin
			pol = $random(seed);
			acc = $random(seed);
			bits = (i < 6) ? (i * 3 + 1) : {$random(seed)} % 20;
			wr(`SPVC_ADDR_VCTL, {24'h0, pol, 7'h2});
			arb_accel_en <= acc;
			fair_req_set <= 1'b1;
			pri_req_set <= 1'b1;
			@(posedge core_clk);
			fair_req_set <= 1'b0;
			pri_req_set <= 1'b0;
			pkt_rx_done <= 1'b1;
			pkt_rx_bits <= 16'(bits);
			@(posedge core_clk);
			pkt_rx_done <= 1'b0;
			@(negedge core_clk);
			chk(fair_req_pending, !clears(pol, acc, bits), "fair pending");
			chk(pri_req_pending, !clears(pol, acc, bits), "pri pending");
		end
		$display("test requests done");
		// Written class overrides the straps
		for (i = 0; i < 8; i++)
		begin
			wr(`SPVC_ADDR_PWR, 32'(i));
			rd(`SPVC_ADDR_PWR);
			chk(q, 32'(i), "power readback");
			chk(self_id_power_field, i[2:0], "self-ID power");
			chk_kind(power_class_kind, exp_kind(i[2:0]));
			rd(`SPVC_ADDR_STAT);
			chk(q[2:0], i[2:0], "status power field");
		end
		$display("test power done");
		// Soft reset restores defaults and reloads new straps
		s = $random(seed);
		power_class_straps <= s;
		arb_accel_en <= 1'b0;
		fair_req_set <= 1'b1;
		wr(`SPVC_ADDR_VCTL, 32'h80);
		fair_req_set <= 1'b0;
		// Reset word read with page 7 still selected, after other bits were written
		wr(`SPVC_ADDR_VRST, 32'h7F);
		rd(`SPVC_ADDR_VRST);
		chk(q, 32'h0, "reset word readback");
		wr(`SPVC_ADDR_VRST, 32'h80);
		@(negedge core_clk);
		chk(soft_reset_active, 1'b1, "soft reset start");
		rd(`SPVC_ADDR_VRST);
		chk(q, 32'h0, "reset bit read");
		n = 0;
		while (soft_reset_active !== 1'b0 && n < 20)
		begin
			@(posedge core_clk);
			n++;
		end
		repeat (3) @(posedge core_clk);
		chk(fair_req_pending, 1'b0, "pending after reset");
		chk(self_id_power_field, s, "strap reload");
		wr(`SPVC_ADDR_PAGE, 32'hE0);
		rd(`SPVC_ADDR_VCTL);
		chk(q, 32'h02, "fields after soft reset");
		$display("test soft reset done");
		complete_run;
	end
endmodule

bind spvc_top spvc_top_properties #(.PKT_BITS_W(PKT_BITS_W)) u_chk (.core_clk(core_clk),
	.resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
	.hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
	.pkt_rx_done(pkt_rx_done), .pkt_rx_bits(pkt_rx_bits), .fair_req_set(fair_req_set),
	.pri_req_set(pri_req_set), .fair_req_pending(fair_req_pending),
	.pri_req_pending(pri_req_pending), .self_id_speed_field(self_id_speed_field),
	.peer_speed_code(peer_speed_code), .soft_reset_active(soft_reset_active));

// *** rtl/spvc_map.svh ***
// Purpose: Constants of the serial-bus PHY vendor control bank.
// Assumes: 32-bit AHB-Lite words, one register per aligned word.
// Notes: Byte address of a register is four times its index.
// Notes on behaviour
// - With the policy bit set and acceleration on, requests clear only on packets over 8 bits.
// - With the policy bit set and acceleration on, acks of 8 bits, null and short packets leave requests pending.
// - With the policy bit clear, any non-ack packet clears fair and priority requests.
// - The policy bit is one read/write bit, 0 after hard reset, kept over bus reset.
// - Link speed codes are 00 S100, 01 S200, 10 S400, and 11 is illegal.
// - The link-speed value is copied into the speed field of the sent self-ID packet.
// - Peers are always told S400 during self-ID speed signalling.
// - Hard reset loads link speed with 10 and bus reset leaves it alone.
// - Writing 1 to the software reset bit performs a full hard reset; here it restarts the fields for four cycles but not the bus slave.
// - The software reset bit always reads back as 0.
// - Three strap inputs give the default power class reported in self-ID bits 21 to 23.
// - Straps load after each hard reset and a later power-class write overrides them.
// - Power codes: 000 none, 001-011 self source, 100 bus source, 101 reserved, 11x need link power.
// - Link speed sits in register 8 of page 7 together with the policy bit.
`ifndef SPVC_MAP_SVH
`define SPVC_MAP_SVH

// Register indices
`define SPVC_IDX_PWR      4
`define SPVC_IDX_PAGE     7
`define SPVC_IDX_VCTL     8
`define SPVC_IDX_VRST     14
`define SPVC_IDX_STAT     16
`define SPVC_IDX_PAGED_LO 8
`define SPVC_IDX_PAGED_HI 15

// Byte addresses
`define SPVC_ADDR_PWR  (8'(`SPVC_IDX_PWR * 4))
`define SPVC_ADDR_PAGE (8'(`SPVC_IDX_PAGE * 4))
`define SPVC_ADDR_VCTL (8'(`SPVC_IDX_VCTL * 4))
`define SPVC_ADDR_VRST (8'(`SPVC_IDX_VRST * 4))
`define SPVC_ADDR_STAT (8'(`SPVC_IDX_STAT * 4))

// Field positions
`define SPVC_PAGE_MSB   7
`define SPVC_PAGE_LSB   5
`define SPVC_POLICY_BIT 7
`define SPVC_SPEED_MSB  1
`define SPVC_SPEED_LSB  0
`define SPVC_SWR_BIT    7
`define SPVC_PWR_MSB    2
`define SPVC_PWR_LSB    0
`define SPVC_ST_FAIR    3
`define SPVC_ST_PRI     4
`define SPVC_ST_SPD_MSB 6
`define SPVC_ST_SPD_LSB 5

// Values
`define SPVC_VENDOR_PAGE  3'h7
`define SPVC_PAGE_RST     3'h0
`define SPVC_POLICY_RST   1'h0
`define SPVC_SPEED_S400   2'h2
`define SPVC_SPEED_ILLEGAL 2'h3
`define SPVC_PEER_S400    3'h2
`define SPVC_PWR_RST      3'h0
`define SPVC_ACK_BITS     8
`define SPVC_SWR_CYCLES   3'h4

`endif

// *** rtl/spvc_pkg.sv ***
// Purpose: Types of the serial-bus PHY vendor control bank.
// Assumes: Constants come from spvc_map.svh.
// Notes: Power-class decoding is shared by the bank and its users.
package spvc_pkg;

	// Register selected by a bus address
	typedef enum logic [2:0] {
		SPVC_REG_NONE,
		SPVC_REG_PWR,
		SPVC_REG_PAGE,
		SPVC_REG_VCTL,
		SPVC_REG_VRST,
		SPVC_REG_STAT
	} spvc_reg_t;

	// Soft reset sequencer
	typedef enum logic [0:0] {
		SPVC_RUN,
		SPVC_SOFT_RST
	} spvc_rst_st_t;

	// Meaning of a power-class code
	typedef enum logic [2:0] {
		SPVC_PWR_NONE,
		SPVC_PWR_SELF_SRC,
		SPVC_PWR_BUS_SRC,
		SPVC_PWR_RESERVED,
		SPVC_PWR_NEED_LINK
	} spvc_pwr_kind_t;

	// Classify a power-class code
	function automatic spvc_pwr_kind_t spvc_pwr_kind(input logic [2:0] code);
		spvc_pwr_kind_t k;
		k = SPVC_PWR_NONE;
		case (code)
			3'h0:
				k = SPVC_PWR_NONE;
			3'h1, 3'h2, 3'h3:
				k = SPVC_PWR_SELF_SRC;
			3'h4:
				k = SPVC_PWR_BUS_SRC;
			3'h5:
				k = SPVC_PWR_RESERVED;
			default:
				k = SPVC_PWR_NEED_LINK;
		endcase
		return k;
	endfunction

endpackage

// *** rtl/spvc_req_clear.sv ***
// Purpose: Pending fair and priority requests and their clearing policy.
// Assumes: Packet-end pulse comes with the received data bit count.
// Notes: A set in the clearing cycle keeps the request pending.
`timescale 1ns/100ps
`include "spvc_map.svh"
module spvc_req_clear #(
	parameter int BITS_W = 16
) (
	// Clock and reset
	input  wire logic              core_clk,
	input  wire logic              rst_n,
	// Control
	input  wire logic              policy,
	input  wire logic              arb_accel_en,
	// Packet receive events
	input  wire logic              pkt_rx_done,
	input  wire logic [BITS_W-1:0] pkt_rx_bits,
	// Request events
	input  wire logic              fair_req_set,
	input  wire logic              pri_req_set,
	// Pending state
	output logic                   fair_pend_r,
	output logic                   pri_pend_r
);

	localparam logic [BITS_W-1:0] ACK_BITS = BITS_W'(`SPVC_ACK_BITS);

	logic clr;
	logic fair_pend_nxt;
	logic pri_pend_nxt;

	// Decide whether this packet drops requests; set beats clear
	always_comb
	begin
		if (policy && arb_accel_en)
			clr = pkt_rx_done && (pkt_rx_bits > ACK_BITS);
		else
			clr = pkt_rx_done && (pkt_rx_bits != ACK_BITS);
		fair_pend_nxt = fair_req_set | (fair_pend_r & ~clr);
		pri_pend_nxt  = pri_req_set | (pri_pend_r & ~clr);
	end

	// Request flags
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			fair_pend_r <= 1'b0;
			pri_pend_r  <= 1'b0;
		end
		else
		begin
			fair_pend_r <= fair_pend_nxt;
			pri_pend_r  <= pri_pend_nxt;
		end
	end

endmodule

// *** rtl/spvc_selfid.sv ***
// Purpose: Self-ID speed and power fields, with strap-loaded power class.
// Assumes: Straps are steady around reset release.
// Notes: Straps are taken on the first edge after reset, never under it.
`timescale 1ns/100ps
`include "spvc_map.svh"
module spvc_selfid (
	// Clock and reset
	input  wire logic                   core_clk,
	input  wire logic                   rst_n,
	// Sources
	input  wire logic [2:0]             power_class_straps,
	input  wire logic [1:0]             link_speed,
	input  wire logic                   pwr_wr,
	input  wire logic [2:0]             pwr_wdata,
	// Self-ID fields
	output logic [1:0]                  self_id_speed_field_r,
	output logic [2:0]                  peer_speed_r,
	output logic [2:0]                  pwr_class_r,
	output spvc_pkg::spvc_pwr_kind_t    pwr_kind_r
);

	logic                       load_pend_r;
	logic                       load_pend_nxt;
	logic [2:0]                 pwr_class_nxt;
	spvc_pkg::spvc_pwr_kind_t   pwr_kind_nxt;

	// Power class: straps after reset, software write after that
	always_comb
	begin
		load_pend_nxt = 1'b0;
		pwr_class_nxt = pwr_class_r;
		if (pwr_wr)
			pwr_class_nxt = pwr_wdata;
		else if (load_pend_r)
			pwr_class_nxt = power_class_straps;
		pwr_kind_nxt = spvc_pkg::spvc_pwr_kind(pwr_class_nxt);
	end

	// Field registers
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			load_pend_r           <= 1'b1;
			pwr_class_r           <= `SPVC_PWR_RST;
			pwr_kind_r            <= spvc_pkg::SPVC_PWR_NONE;
			self_id_speed_field_r <= `SPVC_SPEED_S400;
			peer_speed_r          <= `SPVC_PEER_S400;
		end
		else
		begin
			load_pend_r           <= load_pend_nxt;
			pwr_class_r           <= pwr_class_nxt;
			pwr_kind_r            <= pwr_kind_nxt;
			self_id_speed_field_r <= link_speed;
			peer_speed_r          <= `SPVC_PEER_S400;
		end
	end

endmodule

// *** rtl/spvc_top.sv ***
// Purpose: Vendor control bank of a three-port serial-bus PHY on AHB-Lite.
// Assumes: Single-word transfers; one slave, so hready mirrors hreadyout.
// Notes: Soft reset restarts the fields but never the bus slave itself.
`timescale 1ns/100ps
`include "spvc_map.svh"
module spvc_top #(
	parameter int PKT_BITS_W = 16
) (
	// Clock and reset
	input  wire logic                  core_clk,
	input  wire logic                  resetn,
	// AHB-Lite slave
	input  wire logic                  hsel,
	input  wire logic [31:0]           haddr,
	input  wire logic [1:0]            htrans,
	input  wire logic                  hwrite,
	input  wire logic [2:0]            hsize,
	input  wire logic [31:0]           hwdata,
	input  wire logic                  hready,
	output logic                       hreadyout,
	output logic [31:0]                hrdata,
	output logic                       hresp,
	// Arbitration events
	input  wire logic                  arb_accel_en,
	input  wire logic                  pkt_rx_done,
	input  wire logic [PKT_BITS_W-1:0] pkt_rx_bits,
	input  wire logic                  fair_req_set,
	input  wire logic                  pri_req_set,
	// Straps
	input  wire logic [2:0]            power_class_straps,
	// Arbitration state
	output logic                       fair_req_pending,
	output logic                       pri_req_pending,
	// Self-ID
	output logic [1:0]                 self_id_speed_field,
	output logic [2:0]                 peer_speed_code,
	output logic [2:0]                 self_id_power_field,
	output spvc_pkg::spvc_pwr_kind_t   power_class_kind,
	// Soft reset in progress
	output logic                       soft_reset_active
);

	// Map an address to a register, page 7 gating the upper bank
	function automatic spvc_pkg::spvc_reg_t reg_of(
		input logic [7:0] addr,
		input logic [2:0] page
	);
		spvc_pkg::spvc_reg_t r;
		r = spvc_pkg::SPVC_REG_NONE;
		if (addr == `SPVC_ADDR_PWR)
			r = spvc_pkg::SPVC_REG_PWR;
		else if (addr == `SPVC_ADDR_PAGE)
			r = spvc_pkg::SPVC_REG_PAGE;
		else if (addr == `SPVC_ADDR_STAT)
			r = spvc_pkg::SPVC_REG_STAT;
		else if (page != `SPVC_VENDOR_PAGE)
			r = spvc_pkg::SPVC_REG_NONE;
		else if (addr == `SPVC_ADDR_VCTL)
			r = spvc_pkg::SPVC_REG_VCTL;
		else if (addr == `SPVC_ADDR_VRST)
			r = spvc_pkg::SPVC_REG_VRST;
		return r;
	endfunction

	// Bus phase state
	logic                  wr_pend_r;
	logic                  wr_pend_nxt;
	spvc_pkg::spvc_reg_t   wr_reg_r;
	spvc_pkg::spvc_reg_t   wr_reg_nxt;
	logic [31:0]           hrdata_nxt;
	logic                  addr_ok;
	spvc_pkg::spvc_reg_t   rd_reg;

	// Field state
	logic [2:0]            page_r;
	logic [2:0]            page_nxt;
	logic                  policy_r;
	logic                  policy_nxt;
	logic [1:0]            speed_r;
	logic [1:0]            speed_nxt;
	logic                  pwr_wr;

	// Soft reset state
	spvc_pkg::spvc_rst_st_t rst_st_r;
	spvc_pkg::spvc_rst_st_t rst_st_nxt;
	logic [2:0]            rst_cnt_r;
	logic [2:0]            rst_cnt_nxt;
	logic                  swr_hit;
	logic                  core_rst_n;

	// Sub-block outputs
	logic [2:0]            pwr_class;

	// Fields restart on either the pin or the soft sequencer
	assign core_rst_n = resetn && (rst_st_r == spvc_pkg::SPVC_RUN);

	// Address phase taken when selected, active and bus ready
	assign addr_ok = hsel && hready && htrans[1];
	assign rd_reg  = reg_of(haddr[7:0], page_nxt);

	// Data-phase write into the fields
	always_comb
	begin
		page_nxt   = page_r;
		policy_nxt = policy_r;
		speed_nxt  = speed_r;
		pwr_wr     = 1'b0;
		swr_hit    = 1'b0;
		if (wr_pend_r)
		begin
			case (wr_reg_r)
				spvc_pkg::SPVC_REG_PAGE:
					page_nxt = hwdata[`SPVC_PAGE_MSB:`SPVC_PAGE_LSB];
				spvc_pkg::SPVC_REG_VCTL:
				begin
					policy_nxt = hwdata[`SPVC_POLICY_BIT];
					// Illegal speed code is dropped, keeping the old value
					if (hwdata[`SPVC_SPEED_MSB:`SPVC_SPEED_LSB] != `SPVC_SPEED_ILLEGAL)
						speed_nxt = hwdata[`SPVC_SPEED_MSB:`SPVC_SPEED_LSB];
				end
				spvc_pkg::SPVC_REG_VRST:
					swr_hit = hwdata[`SPVC_SWR_BIT];
				spvc_pkg::SPVC_REG_PWR:
					pwr_wr = 1'b1;
				default:
					pwr_wr = 1'b0;
			endcase
		end
	end

	// Bus slave: capture the write, answer page and control reads from next values
	always_comb
	begin
		wr_pend_nxt = addr_ok && hwrite;
		wr_reg_nxt  = spvc_pkg::SPVC_REG_NONE;
		hrdata_nxt  = 32'h0000_0000;
		if (addr_ok && hwrite)
			wr_reg_nxt = reg_of(haddr[7:0], page_nxt);
		// Next values let a read see a write just ahead of it
		if (addr_ok && !hwrite)
		begin
			if (rd_reg == spvc_pkg::SPVC_REG_PAGE)
				hrdata_nxt[`SPVC_PAGE_MSB:`SPVC_PAGE_LSB] = page_nxt;
			else if (rd_reg == spvc_pkg::SPVC_REG_VCTL)
			begin
				hrdata_nxt[`SPVC_POLICY_BIT] = policy_nxt;
				hrdata_nxt[`SPVC_SPEED_MSB:`SPVC_SPEED_LSB] = speed_nxt;
			end
			else if (rd_reg == spvc_pkg::SPVC_REG_VRST)
				hrdata_nxt = 32'h0000_0000;
			else if (rd_reg == spvc_pkg::SPVC_REG_PWR)
				hrdata_nxt[`SPVC_PWR_MSB:`SPVC_PWR_LSB] = pwr_class;
			else if (rd_reg == spvc_pkg::SPVC_REG_STAT)
			begin
				hrdata_nxt[`SPVC_PWR_MSB:`SPVC_PWR_LSB] = self_id_power_field;
				hrdata_nxt[`SPVC_ST_FAIR] = fair_req_pending;
				hrdata_nxt[`SPVC_ST_PRI]  = pri_req_pending;
				hrdata_nxt[`SPVC_ST_SPD_MSB:`SPVC_ST_SPD_LSB] = self_id_speed_field;
			end
		end
	end

	// Soft reset sequencer; the bit itself is never stored
	always_comb
	begin
		rst_st_nxt  = rst_st_r;
		rst_cnt_nxt = rst_cnt_r;
		case (rst_st_r)
			spvc_pkg::SPVC_RUN:
			begin
				if (swr_hit)
				begin
					rst_st_nxt  = spvc_pkg::SPVC_SOFT_RST;
					rst_cnt_nxt = `SPVC_SWR_CYCLES;
				end
			end
			spvc_pkg::SPVC_SOFT_RST:
			begin
				rst_cnt_nxt = rst_cnt_r - 3'h1;
				if (rst_cnt_r == 3'h1)
					rst_st_nxt = spvc_pkg::SPVC_RUN;
			end
			default:
				rst_st_nxt = spvc_pkg::SPVC_RUN;
		endcase
	end

	// Bus and sequencer registers, only the pin resets them
	always_ff @(posedge core_clk)
	begin
		if (!resetn)
		begin
			wr_pend_r         <= 1'b0;
			wr_reg_r          <= spvc_pkg::SPVC_REG_NONE;
			hrdata            <= 32'h0000_0000;
			hreadyout         <= 1'b1;
			hresp             <= 1'b0;
			rst_st_r          <= spvc_pkg::SPVC_RUN;
			rst_cnt_r         <= 3'h0;
			soft_reset_active <= 1'b0;
		end
		else
		begin
			wr_pend_r         <= wr_pend_nxt;
			wr_reg_r          <= wr_reg_nxt;
			hrdata            <= hrdata_nxt;
			hreadyout         <= 1'b1; // No wait states
			hresp             <= 1'b0; // Always OKAY
			rst_st_r          <= rst_st_nxt;
			rst_cnt_r         <= rst_cnt_nxt;
			soft_reset_active <= (rst_st_nxt == spvc_pkg::SPVC_SOFT_RST);
		end
	end

	// Fields: pin or soft reset restores defaults; bus reset does not reach here
	always_ff @(posedge core_clk)
	begin
		if (!core_rst_n)
		begin
			page_r   <= `SPVC_PAGE_RST;
			policy_r <= `SPVC_POLICY_RST;
			speed_r  <= `SPVC_SPEED_S400;
		end
		else
		begin
			page_r   <= page_nxt;
			policy_r <= policy_nxt;
			speed_r  <= speed_nxt;
		end
	end

	// Request clearing under the null-packet policy
	spvc_req_clear #(
		.BITS_W        (PKT_BITS_W)
	) u_req (
		.core_clk      (core_clk),
		.rst_n         (core_rst_n),
		.policy        (policy_r),
		.arb_accel_en  (arb_accel_en),
		.pkt_rx_done   (pkt_rx_done),
		.pkt_rx_bits   (pkt_rx_bits),
		.fair_req_set  (fair_req_set),
		.pri_req_set   (pri_req_set),
		.fair_pend_r   (fair_req_pending),
		.pri_pend_r    (pri_req_pending)
	);

	// Self-ID fields and power class
	spvc_selfid u_sid (
		.core_clk              (core_clk),
		.rst_n                 (core_rst_n),
		.power_class_straps    (power_class_straps),
		.link_speed            (speed_r),
		.pwr_wr                (pwr_wr),
		.pwr_wdata             (hwdata[`SPVC_PWR_MSB:`SPVC_PWR_LSB]),
		.self_id_speed_field_r (self_id_speed_field),
		.peer_speed_r          (peer_speed_code),
		.pwr_class_r           (pwr_class),
		.pwr_kind_r            (power_class_kind)
	);

	// Power field of the self-ID packet tracks the class register
	assign self_id_power_field = pwr_class;

endmodule
